//--- common/ext_bus_pkg.sv
// constants and carrier types for the multiplexed expansion bus pin block
package ext_bus_pkg;

	// ==================== timing ====================
	localparam int CLK_PERIOD_PS = 5000;
	localparam int RST_MIN_NS    = 50;
	localparam int RST_MIN_CYC   = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ==================== register map ====================
	localparam logic [7:0] AD_CFG_OFS  = 8'h00;
	localparam logic [7:0] AD_DATA_OFS = 8'h04;
	localparam logic [7:0] UP_CFG_OFS  = 8'h08;
	localparam logic [7:0] CTL_CFG_OFS = 8'h0C;
	localparam logic [7:0] STATUS_OFS  = 8'h10;
	localparam logic [7:0] PIN_IN_OFS  = 8'h14;
	localparam int         CFG_WORDS   = 4;
	localparam logic [31:0] AD_CFG_MASK  = 32'hFFFFFFFF;
	localparam logic [31:0] AD_DATA_MASK = 32'h0000FFFF;
	localparam logic [31:0] UP_CFG_MASK  = 32'h003F3F3F;
	localparam logic [31:0] CTL_CFG_MASK = 32'h013F0FFF;
	localparam logic [31:0] CFG_RESET    = 32'h00000000;

	// ==================== field positions ====================
	localparam int UP_FSEL_LSB = 0;
	localparam int UP_DIR_LSB  = 8;
	localparam int UP_OUT_LSB  = 16;
	localparam int ST_FSEL_LSB = 0;
	localparam int ST_DIR_LSB  = 4;
	localparam int ST_OUT_LSB  = 8;
	localparam int CW_FSEL_LSB = 16;
	localparam int CW_DIR_LSB  = 18;
	localparam int CW_OUT_LSB  = 20;
	localparam int STANDBY_BIT = 24;

	// ==================== types ====================
	typedef enum logic [1:0] {MODE_ROMLESS, MODE_SINGLE, MODE_FLASH, MODE_PROHIBITED} mode_type;
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_DATA, S_WAIT, S_END} bus_state_type;

	typedef struct packed {
		logic        write;
		logic [1:0]  byte_en;
		logic [21:0] addr;
		logic [15:0] wdata;
	} req_type;

	typedef struct packed {
		logic [15:0] ad;
		logic        ad_oe;
		logic [5:0]  up;
		logic        address_latch_strobe_n;
		logic        rd_n;
		logic        uwr_n;
		logic        lwr_n;
	} bus_drive_type;

endpackage : ext_bus_pkg

//--- logic/ext_mux_bus_pins.sv
// expansion bus sequencer, pin function multiplexing and mode capture
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps

// Functional notes
// - sample wait request at bus clock fall in data and wait states.
// - wait request is asynchronous and passes a two-stage synchroniser.
// - low write strobe active at fall in address state, off at data fall.
// - high write strobe active at fall in address state, off at data fall.
// - read strobe marks reads and stays inactive while idle.
// - latch strobe low at address-state fall, high at end-state fall.
// - mux bus carries address bits 15:0 first, then 16-bit data.
// - upper address pins carry address bits 21:16 during an access.
// - single-chip mode drives bus clock only when its pin selects control.
// - romless mode drives the clock pin always; bus clock runs through a pin reset, low in system reset and standby.
// - mode latched from mode pins during reset; pins held constant by others.
// - both low romless, a high b low single-chip, prog voltage with a high flash.
// - long low on async reset pin resets all but the bus clock divider and wishbone ack and read data, and ends standby.
// - every multifunction pin has its own port/function select bit.
// - address/data pins in port mode have per-bit direction.
// - upper address pins output address when their select bits are set.
// - four strobe pins output write, read and latch strobes in control mode.
// - wait input and clock output each selected individually.
// - standby floats address pins, strobes high, clock output low.
module ext_mux_bus_pins (
	// clock, reset, enable
	input  wire logic                   CLK_IN,
	input  wire logic                   SYS_RST_IN,
	input  wire logic                   CLK_EN_IN,
	// wishbone slave
	input  wire logic                   WB_CYC_IN,
	input  wire logic                   WB_STB_IN,
	input  wire logic                   WB_WE_IN,
	input  wire logic [7:0]             WB_ADR_IN,
	input  wire logic [3:0]             WB_SEL_IN,
	input  wire logic [31:0]            WB_DAT_IN,
	output logic      [31:0]            WB_DAT_OUT,
	output logic                        WB_ACK_OUT,
	// access requests from cpu side
	input  wire logic                   REQ_VALID_IN,
	input  wire ext_bus_pkg::req_type   REQ_IN,
	output logic                        REQ_READY_OUT,
	output logic                        DONE_OUT,
	output logic      [15:0]            RDATA_OUT,
	output ext_bus_pkg::mode_type       MODE_OUT,
	// reset and mode pins
	input  wire logic                   RESET_N_IN,
	input  wire logic                   MODE_PIN_A_IN,
	input  wire logic                   MODE_PIN_B_IN,
	input  wire logic                   PROG_VOLT_IN,
	// address/data pins
	input  wire logic [15:0]            AD_PINS_IN,
	output logic      [15:0]            AD_PINS_OUT,
	output logic      [15:0]            AD_PINS_OE_OUT,
	// upper address pins
	input  wire logic [5:0]             UP_PINS_IN,
	output logic      [5:0]             UP_PINS_OUT,
	output logic      [5:0]             UP_PINS_OE_OUT,
	// strobe pins: 0 low write, 1 high write, 2 read, 3 latch
	input  wire logic [3:0]             ST_PINS_IN,
	output logic      [3:0]             ST_PINS_OUT,
	output logic      [3:0]             ST_PINS_OE_OUT,
	// clock/wait pins: 0 wait, 1 clock
	input  wire logic [1:0]             CW_PINS_IN,
	output logic      [1:0]             CW_PINS_OUT,
	output logic      [1:0]             CW_PINS_OE_OUT
);

	// ==================== declarations ====================
	logic [31:0]                cfg [ext_bus_pkg::CFG_WORDS];
	logic [31:0]                sync1;
	logic [31:0]                sync2;
	logic [7:0]                 rst_cnt;
	logic                       pin_rst;
	logic                       rst;
	logic                       bus_clk;
	logic                       rise;
	logic                       fall;
	logic                       pend;
	logic                       acc;
	logic                       wait_smp;
	logic                       wait_req;
	logic                       stby;
	logic                       romless;
	logic                       fin;
	ext_bus_pkg::req_type       cur;
	ext_bus_pkg::bus_drive_type drv;
	ext_bus_pkg::bus_state_type st;
	logic [31:0]                next_rd;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic [31:0] cfg_mask(input int idx);
		logic [31:0] m;
		m = ext_bus_pkg::CTL_CFG_MASK;
		if (idx == 0) m = ext_bus_pkg::AD_CFG_MASK;
		if (idx == 1) m = ext_bus_pkg::AD_DATA_MASK;
		if (idx == 2) m = ext_bus_pkg::UP_CFG_MASK;
		return m;
	endfunction : cfg_mask

	function automatic ext_bus_pkg::mode_type decode_mode(input logic a, input logic b,
		input logic prog);
		ext_bus_pkg::mode_type m;
		m = ext_bus_pkg::MODE_PROHIBITED;
		if (prog && a) m = ext_bus_pkg::MODE_FLASH;
		else if (!prog && !a && !b) m = ext_bus_pkg::MODE_ROMLESS;
		else if (!prog && a && !b) m = ext_bus_pkg::MODE_SINGLE;
		return m;
	endfunction : decode_mode

	// ==================== pin synchronisers ====================
	// every pin input, wait included, crosses two flops
	always_ff @(posedge CLK_IN) begin
		if (CLK_EN_IN) begin
			sync1 <= {PROG_VOLT_IN, MODE_PIN_B_IN, MODE_PIN_A_IN, RESET_N_IN,
				CW_PINS_IN, ST_PINS_IN, UP_PINS_IN, AD_PINS_IN};
			sync2 <= sync1;
		end
	end

	// ==================== reset pin filter ====================
	// low must persist before it counts; glitches are ignored
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			rst_cnt <= 8'h00;
			pin_rst <= 1'b0;
		end else if (CLK_EN_IN) begin
			if (sync2[28]) begin
				rst_cnt <= 8'h00;
			end else if (rst_cnt != 8'(ext_bus_pkg::RST_MIN_CYC)) begin
				rst_cnt <= rst_cnt + 8'h01;
			end
			pin_rst <= !sync2[28] && (rst_cnt == 8'(ext_bus_pkg::RST_MIN_CYC));
		end
	end

	assign rst = SYS_RST_IN || pin_rst;

	// ==================== mode capture ====================
	// track pins only while reset is held, frozen afterwards
	always_ff @(posedge CLK_IN) begin
		if (rst && CLK_EN_IN) begin
			MODE_OUT <= decode_mode(sync2[29], sync2[30], sync2[31]);
		end
	end

	assign romless = (MODE_OUT == ext_bus_pkg::MODE_ROMLESS);

	// ==================== bus clock divider ====================
	// a pin reset keeps the divider running so romless output survives it
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			bus_clk <= 1'b0;
		end else if (CLK_EN_IN) begin
			bus_clk <= !bus_clk;
		end
	end

	assign rise = CLK_EN_IN && !bus_clk;
	assign fall = CLK_EN_IN && bus_clk;

	// ==================== register file ====================
	assign stby = cfg[3][ext_bus_pkg::STANDBY_BIT];

	always_ff @(posedge CLK_IN) begin
		if (rst) begin
			for (int i = 0; i < ext_bus_pkg::CFG_WORDS; i++) begin
				cfg[i] <= ext_bus_pkg::CFG_RESET;
			end
		end else if (CLK_EN_IN && WB_CYC_IN && WB_STB_IN && WB_WE_IN && !WB_ACK_OUT) begin
			for (int i = 0; i < ext_bus_pkg::CFG_WORDS; i++) begin
				if (WB_ADR_IN[7:2] == 6'(i)) begin
					cfg[i] <= merge(cfg[i], WB_DAT_IN, WB_SEL_IN) & cfg_mask(i);
				end
			end
		end
	end

	always_comb begin
		next_rd = 32'h00000000;
		unique case (WB_ADR_IN[7:2])
			ext_bus_pkg::AD_CFG_OFS[7:2]:  next_rd = cfg[0];
			ext_bus_pkg::AD_DATA_OFS[7:2]: next_rd = cfg[1];
			ext_bus_pkg::UP_CFG_OFS[7:2]:  next_rd = cfg[2];
			ext_bus_pkg::CTL_CFG_OFS[7:2]: next_rd = cfg[3];
			ext_bus_pkg::STATUS_OFS[7:2]:  next_rd = {28'h0000000, stby, st != ext_bus_pkg::S_IDLE,
				MODE_OUT};
			ext_bus_pkg::PIN_IN_OFS[7:2]:  next_rd = {4'h0, sync2[27:0]};
			default:                       next_rd = 32'h00000000;
		endcase
	end

	// unmapped reads answer zero, unmapped writes are dropped
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			WB_ACK_OUT <= 1'b0;
			WB_DAT_OUT <= 32'h00000000;
		end else if (CLK_EN_IN) begin
			WB_ACK_OUT <= WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
			WB_DAT_OUT <= next_rd;
		end
	end

	// ==================== request intake ====================
	assign acc = REQ_VALID_IN && REQ_READY_OUT;

	always_ff @(posedge CLK_IN) begin
		if (rst) begin
			REQ_READY_OUT <= 1'b0;
			pend          <= 1'b0;
			cur           <= '0;
		end else if (CLK_EN_IN) begin
			REQ_READY_OUT <= !stby && st == ext_bus_pkg::S_IDLE && !pend && !acc;
			if (acc) begin
				pend <= 1'b1;
				cur  <= REQ_IN;
			end else if (rise && st == ext_bus_pkg::S_IDLE && !stby) begin
				pend <= 1'b0;
			end
		end
	end

	// ==================== bus sequencer ====================
	assign wait_req = cfg[3][ext_bus_pkg::CW_FSEL_LSB] && !sync2[26];

	// states advance on bus clock rises
	always_ff @(posedge CLK_IN) begin
		if (rst) begin
			st <= ext_bus_pkg::S_IDLE;
		end else if (rise) begin
			unique case (st)
				ext_bus_pkg::S_IDLE: if (pend && !stby) st <= ext_bus_pkg::S_ADDR;
				ext_bus_pkg::S_ADDR: st <= ext_bus_pkg::S_DATA;
				ext_bus_pkg::S_DATA,
				ext_bus_pkg::S_WAIT: st <= wait_smp ? ext_bus_pkg::S_WAIT : ext_bus_pkg::S_END;
				ext_bus_pkg::S_END:  st <= ext_bus_pkg::S_IDLE;
			endcase
		end
	end

	// sampled at falls in data and wait states
	always_ff @(posedge CLK_IN) begin
		if (rst) begin
			wait_smp <= 1'b0;
		end else if (fall && (st == ext_bus_pkg::S_DATA || st == ext_bus_pkg::S_WAIT)) begin
			wait_smp <= wait_req;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (rst) begin
			drv <= '{ad: 16'h0000, ad_oe: 1'b0, up: 6'h00, default: 1'b1};
		end else if (rise) begin
			// address out from the start of the address state
			if (st == ext_bus_pkg::S_IDLE && pend && !stby) begin
				drv.ad    <= cur.addr[15:0];
				drv.ad_oe <= 1'b1;
				drv.up    <= cur.addr[21:16];
			end
			if (st == ext_bus_pkg::S_END) begin
				drv.ad_oe <= 1'b0;
			end
		end else if (fall) begin
			if (st == ext_bus_pkg::S_ADDR) begin
				drv.address_latch_strobe_n <= 1'b0;
				drv.rd_n   <= cur.write;
				drv.lwr_n  <= !(cur.write && cur.byte_en[0]);
				drv.uwr_n  <= !(cur.write && cur.byte_en[1]);
			end
			if (st == ext_bus_pkg::S_DATA) begin
				drv.lwr_n <= 1'b1;
				drv.uwr_n <= 1'b1;
				// data phase turns the bus round for reads
				drv.ad    <= cur.wdata;
				drv.ad_oe <= cur.write;
			end
			if (st == ext_bus_pkg::S_END) begin
				drv.address_latch_strobe_n <= 1'b1;
				drv.rd_n   <= 1'b1;
			end
		end
	end

	// read data taken one cycle late: pin output enable and sync lag would show the address
	always_ff @(posedge CLK_IN) begin
		if (rst) begin
			fin       <= 1'b0;
			DONE_OUT  <= 1'b0;
			RDATA_OUT <= 16'h0000;
		end else if (CLK_EN_IN) begin
			fin      <= rise && st == ext_bus_pkg::S_END;
			DONE_OUT <= fin;
			if (fin) begin
				RDATA_OUT <= sync2[15:0];
			end
		end
	end

	// ==================== pin multiplexing ====================
	always_ff @(posedge CLK_IN) begin
		if (rst) begin
			AD_PINS_OUT    <= 16'h0000;
			AD_PINS_OE_OUT <= 16'h0000;
			UP_PINS_OUT    <= 6'h00;
			UP_PINS_OE_OUT <= 6'h00;
			ST_PINS_OUT    <= 4'h0;
			ST_PINS_OE_OUT <= 4'h0;
			// romless clock keeps running through a pin reset, held low during system reset
			CW_PINS_OUT    <= {romless && bus_clk, 1'b0};
			CW_PINS_OE_OUT <= {romless, 1'b0};
		end else if (CLK_EN_IN) begin
			AD_PINS_OUT    <= (cfg[0][15:0] & drv.ad) | (~cfg[0][15:0] & cfg[1][15:0]);
			AD_PINS_OE_OUT <= (cfg[0][15:0] & {16{drv.ad_oe && !stby}})
				| (~cfg[0][15:0] & cfg[0][31:16]);
			UP_PINS_OUT    <= (cfg[2][5:0] & drv.up) | (~cfg[2][5:0] & cfg[2][21:16]);
			UP_PINS_OE_OUT <= (cfg[2][5:0] & {6{!stby}}) | (~cfg[2][5:0] & cfg[2][13:8]);
			ST_PINS_OUT    <= (cfg[3][3:0] & (stby ? 4'hF : {drv.address_latch_strobe_n, drv.rd_n, drv.uwr_n,
				drv.lwr_n})) | (~cfg[3][3:0] & cfg[3][11:8]);
			ST_PINS_OE_OUT <= cfg[3][3:0] | cfg[3][7:4];
			// wait pin becomes input when selected
			CW_PINS_OUT[0]    <= !cfg[3][16] && cfg[3][20];
			CW_PINS_OE_OUT[0] <= !cfg[3][16] && cfg[3][18];
			// clock output selection, low in standby
			CW_PINS_OUT[1]    <= (cfg[3][17] || romless) ? (bus_clk && !stby) : cfg[3][21];
			CW_PINS_OE_OUT[1] <= cfg[3][17] || romless || cfg[3][19];
		end
	end

	// ==================== assertions ====================
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	property p_wait_insert;
		rise && !rst && (st == ext_bus_pkg::S_DATA || st == ext_bus_pkg::S_WAIT) && wait_smp
			|=> st == ext_bus_pkg::S_WAIT;
	endproperty
	a_wait_insert: assert property (p_wait_insert) else $error("wait state not inserted");

	property p_wait_sample;
		fall && !rst && st == ext_bus_pkg::S_DATA |=> wait_smp == $past(wait_req);
	endproperty
	a_wait_sample: assert property (p_wait_sample) else $error("wait not sampled");

	property p_wait_sync;
		CLK_EN_IN ##1 CLK_EN_IN |-> wait_req == (cfg[3][16] && !$past(sync1[26]));
	endproperty
	a_wait_sync: assert property (p_wait_sync) else $error("wait bypassed synchroniser");

	property p_low_write;
		fall && !rst && st == ext_bus_pkg::S_ADDR && cur.write && cur.byte_en[0]
			|=> !drv.lwr_n ##1 !drv.lwr_n ##1 drv.lwr_n;
	endproperty
	a_low_write: assert property (p_low_write) else $error("low write strobe timing");

	property p_high_write;
		fall && !rst && st == ext_bus_pkg::S_ADDR && cur.write && cur.byte_en[1]
			|=> !drv.uwr_n ##1 !drv.uwr_n ##1 drv.uwr_n;
	endproperty
	a_high_write: assert property (p_high_write) else $error("high write strobe timing");

	property p_read_idle;
		st == ext_bus_pkg::S_IDLE && $past(st) == ext_bus_pkg::S_IDLE |-> drv.rd_n;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read strobe active while idle");

	property p_latch_strobe;
		fall && !rst && st == ext_bus_pkg::S_ADDR |=> !drv.address_latch_strobe_n ##2 !drv.address_latch_strobe_n;
	endproperty
	a_latch_strobe: assert property (p_latch_strobe) else $error("latch strobe not low");

	property p_addr_out;
		rise && !rst && st == ext_bus_pkg::S_IDLE && pend && !stby
			|=> drv.ad == cur.addr[15:0] && drv.ad_oe && drv.up == cur.addr[21:16];
	endproperty
	a_addr_out: assert property (p_addr_out) else $error("address not on bus");

	property p_romless_clock;
		romless && CLK_EN_IN |=> CW_PINS_OE_OUT[1];
	endproperty
	a_romless_clock: assert property (p_romless_clock) else $error("romless clock not driven");

	property p_mode_hold;
		!rst ##1 !rst |-> $stable(MODE_OUT);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside reset");

	property p_pin_reset;
		pin_rst |=> st == ext_bus_pkg::S_IDLE && !stby && !REQ_READY_OUT;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset did not clear");

	property p_standby;
		stby && !rst && CLK_EN_IN |=> (AD_PINS_OE_OUT & $past(cfg[0][15:0])) == 16'h0000;
	endproperty
	a_standby: assert property (p_standby) else $error("bus pins driven in standby");

	c_write: cover property (fall && st == ext_bus_pkg::S_ADDR && cur.write);
	c_read_wait: cover property (rise && st == ext_bus_pkg::S_WAIT && !cur.write);
	c_standby: cover property (stby && pend);
	c_pin_reset: cover property (pin_rst);

endmodule : ext_mux_bus_pins

//--- verification/ext_mem_model.sv
// behavioural external memory on the multiplexed bus pins
`timescale 1ns/1ps
module ext_mem_model (
	// clocks
	input  wire logic        clk,
	input  wire logic        lclk,
	// pin levels seen on the board
	input  wire logic [15:0] ad_pin,
	input  wire logic [5:0]  up_pin,
	input  wire logic [3:0]  st_pin,
	input  wire logic [1:0]  wait_len,
	// far side drive
	output logic      [15:0] ad_drv,
	output logic             wait_n,
	output logic      [21:0] addr
);
	logic [15:0] mem [0:255];
	logic [3:0]  st_d   = 4'hF;
	logic [1:0]  be     = 2'h0;
	logic [1:0]  tail   = 2'h0;
	logic [7:0]  lcnt   = 8'h00;
	logic [7:0]  lstart = 8'h00;
	logic        rel    = 1'b0;
	initial foreach (mem[i]) mem[i] = 16'h0000;
	initial ad_drv = 16'h5A5A;
	initial addr = 22'h000000;
	// ==========================================
	// slow peripheral: not ready until some link clock edges pass
	always @(posedge lclk) lcnt <= lcnt + 8'h01;
	assign wait_n = (wait_len == 2'h0) || rel;
	// ==========================================
	// bus side
	always @(posedge clk) begin
		st_d <= st_pin;
		tail <= !st_pin[2] ? 2'h3 : {1'b0, tail[1]};
		// released bus toggles so a stale value never passes
		ad_drv <= (!st_pin[2] || tail != 2'h0) ? mem[addr[7:0]] : ~ad_drv;
		be <= be | ~st_pin[1:0];
		if (st_d[3] && !st_pin[3]) begin
			addr   <= {up_pin, ad_pin};
			lstart <= lcnt;
			be     <= 2'h0;
		end
		if (!st_d[3] && (lcnt - lstart >= {6'h00, wait_len})) rel <= 1'b1;
		if (!st_d[3] && st_pin[3]) begin
			rel <= 1'b0;
			if (be[0]) mem[addr[7:0]][7:0] <= ad_pin[7:0];
			if (be[1]) mem[addr[7:0]][15:8] <= ad_pin[15:8];
		end
	end
endmodule : ext_mem_model

//--- verification/tb_ext_mux_bus_pins.sv
// self-checking bench for the expansion bus pin block
`timescale 1ns/1ps
module tb_ext_mux_bus_pins;
	typedef struct packed {
		logic [21:0] addr;
		logic [3:0]  st;
		logic [7:0]  lmin;
		logic [8:0]  lmax;
		logic        chk;
		logic [15:0] v;
	} note_type;
	logic        clk = 1'b0, lclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        vld = 1'b0, rst_n = 1'b1, ma = 1'b0, mb = 1'b0, pv = 1'b0, bus_on = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, rd, wb_rd;
	logic        ack, ready, done, wait_n;
	logic [15:0] rdata, ad_out, ad_oe, ad_drv, ad_w;
	logic [5:0]  up_out, up_oe, up_w;
	logic [3:0]  st_out, st_oe, st_w, seen = 4'h0;
	logic [1:0]  cw_out, cw_oe, cw_w, wl = 2'h0;
	logic [21:0] maddr;
	logic [15:0] shadow [0:255];
	ext_bus_pkg::req_type  req = '0;
	ext_bus_pkg::mode_type mode;
	note_type    q[$], note;
	integer      seed = 89;
	int          n_fail = 0, compares = 0, cnt = 0, t0 = 0;
	initial foreach (shadow[i]) shadow[i] = 16'h0000;
	always #2.5 clk = ~clk;
	always #62.5 lclk = ~lclk;
	// undriven pins flip so a floating line never reads as last value
	assign ad_w = (ad_oe & ad_out) | (~ad_oe & ad_drv);
	assign up_w = up_out ^ ~up_oe;
	assign st_w = st_out ^ ~st_oe;
	assign cw_w = {cw_out[1] ^ ~cw_oe[1], cw_oe[0] ? cw_out[0] : wait_n};
	ext_mux_bus_pins dut (.CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(1'b1),
		.WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF),
		.WB_DAT_IN(wdat), .WB_DAT_OUT(wb_rd), .WB_ACK_OUT(ack), .REQ_VALID_IN(vld),
		.REQ_IN(req), .REQ_READY_OUT(ready), .DONE_OUT(done), .RDATA_OUT(rdata),
		.MODE_OUT(mode), .RESET_N_IN(rst_n), .MODE_PIN_A_IN(ma), .MODE_PIN_B_IN(mb),
		.PROG_VOLT_IN(pv), .AD_PINS_IN(ad_w), .AD_PINS_OUT(ad_out), .AD_PINS_OE_OUT(ad_oe),
		.UP_PINS_IN(up_w), .UP_PINS_OUT(up_out), .UP_PINS_OE_OUT(up_oe), .ST_PINS_IN(st_w),
		.ST_PINS_OUT(st_out), .ST_PINS_OE_OUT(st_oe), .CW_PINS_IN(cw_w),
		.CW_PINS_OUT(cw_out), .CW_PINS_OE_OUT(cw_oe));
	ext_mem_model mem (.clk(clk), .lclk(lclk), .ad_pin(ad_w), .up_pin(up_w), .st_pin(st_w),
		.wait_len(wl), .ad_drv(ad_drv), .wait_n(wait_n), .addr(maddr));
	// ==========================================
	// shared tasks
	task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
		compares++;
		if (seen_v !== exp_v) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, seen_v, exp_v);
		end
	endtask : check
	task automatic give_verdict;
		$display("counts: %0d compares, %0d mismatches", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) n_fail++;
		rd = wb_rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic wbc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(rd, e); // register value
	endtask : wbc
	task automatic acc(input logic w, input logic [1:0] be, input logic [21:0] a,
		input logic [15:0] d, input logic [1:0] l);
		note_type e;
		int n;
		n = 0;
		if (w && be[0]) shadow[a[7:0]][7:0] = d[7:0];
		if (w && be[1]) shadow[a[7:0]][15:8] = d[15:8];
		e = '{a, {1'b1, !w, w & be[1], w & be[0]},
			(l == 2'h0) ? 8'h09 : ((l == 2'h2) ? 8'h1F : 8'h33),
			(l == 2'h0) ? 9'h00A : 9'h190, !w, shadow[a[7:0]]};
		q.push_back(e);
		wl  <= l;
		req <= '{w, be, a, d};
		vld <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (ready !== 1'b1 && n < 300);
		vld <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (done !== 1'b1 && n < 900);
		if (done !== 1'b1) n_fail++;
	endtask : acc
	// ==========================================
	// result watcher
	always @(posedge clk) begin
		cnt  <= cnt + 1;
		seen <= (vld && ready) ? 4'h0 : (seen | ~st_w);
		if (vld && ready) t0 <= cnt;
		if (bus_on && ready === 1'b1) check({31'h0, st_w[2]}, 32'h1);
		if (done === 1'b1) begin
			if (q.size() == 0) n_fail++;
			else begin
				note = q.pop_front();
				check({10'h0, maddr}, {10'h0, note.addr});
				check({28'h0, seen}, {28'h0, note.st});
				check({31'h0, (cnt - t0 >= note.lmin) && (cnt - t0 <= note.lmax)}, 32'h1);
				if (note.chk) check({16'h0, rdata}, {16'h0, note.v});
			end
		end
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		give_verdict();
	end
	// ==========================================
	// main sequence
	initial begin
		logic [31:0] r;
		logic [31:0] mask [4] = '{ext_bus_pkg::AD_CFG_MASK, ext_bus_pkg::AD_DATA_MASK,
			ext_bus_pkg::UP_CFG_MASK, ext_bus_pkg::CTL_CFG_MASK};
		logic [2:0] straps [5] = '{3'b000, 3'b010, 3'b110, 3'b101, 3'b100};
		ext_bus_pkg::mode_type em [5] = '{ext_bus_pkg::MODE_ROMLESS,
			ext_bus_pkg::MODE_PROHIBITED, ext_bus_pkg::MODE_PROHIBITED,
			ext_bus_pkg::MODE_FLASH, ext_bus_pkg::MODE_SINGLE};
		// straps only change while reset is held
		foreach (straps[i]) begin
			{ma, mb, pv} <= straps[i];
			rst <= 1'b1;
			repeat (20) @(posedge clk);
			check({30'h0, mode}, {30'h0, em[i]});
			check({31'h0, cw_oe[1]}, {31'h0, em[i] == ext_bus_pkg::MODE_ROMLESS});
			rst <= 1'b0;
			@(posedge clk);
		end
		@(posedge clk);
		$display("test modes done");
		for (int i = 0; i < 4; i++) begin
			wbc(8'(4 * i), 32'h0);
			r = $random(seed);
			wb(1'b1, 8'(4 * i), r);
			wbc(8'(4 * i), r & mask[i]);
		end
		wbc(8'h20, 32'h0);
		wb(1'b1, ext_bus_pkg::CTL_CFG_OFS, 32'h0);
		wb(1'b1, ext_bus_pkg::STATUS_OFS, 32'hFFFFFFFF);
		wbc(ext_bus_pkg::STATUS_OFS, 32'h1);
		check({31'h0, cw_oe[1]}, 32'h0); // port until selected
		wb(1'b1, ext_bus_pkg::CTL_CFG_OFS, 32'h00020000);
		repeat (4) @(posedge clk);
		check({31'h0, cw_oe[1]}, 32'h1); // clock selected
		$display("test registers done");
		r = $random(seed);
		wb(1'b1, ext_bus_pkg::AD_CFG_OFS, 32'hFFFF0000);
		wb(1'b1, ext_bus_pkg::AD_DATA_OFS, r);
		wb(1'b1, ext_bus_pkg::UP_CFG_OFS, {10'h000, r[5:0], 16'h3F00});
		repeat (3) @(posedge clk);
		check({ad_oe, ad_out}, {16'hFFFF, r[15:0]}); // port output
		check({26'h0, up_out}, {26'h0, r[5:0]}); // port mode
		wb(1'b0, ext_bus_pkg::PIN_IN_OFS, 32'h0);
		check(rd & 32'h003FFFFF, {10'h0, r[5:0], r[15:0]}); // pins read back
		$display("test port mode done");
		wb(1'b1, ext_bus_pkg::AD_CFG_OFS, 32'h0000FFFF);
		wb(1'b1, ext_bus_pkg::UP_CFG_OFS, 32'h0000003F);
		wb(1'b1, ext_bus_pkg::CTL_CFG_OFS, 32'h0003000F);
		bus_on <= 1'b1;
		check({30'h0, cw_oe}, 32'h2); // wait in clock out
		repeat (8) begin
			r = $random(seed);
			acc(1'b1, (r[23:22] == 2'h0) ? 2'h3 : r[23:22], r[21:0], r[31:16],
				(r[25:24] == 2'h1) ? 2'h0 : r[25:24]);
			acc(1'b0, 2'h3, r[21:0], 16'h0000, (r[27:26] == 2'h1) ? 2'h2 : r[27:26]);
		end
		$display("test transfers done");
		bus_on <= 1'b0;
		wb(1'b1, ext_bus_pkg::CTL_CFG_OFS, 32'h0103000F);
		repeat (6) @(posedge clk);
		check({24'h0, st_oe, st_out}, 32'hFF); // strobes high
		check({ad_oe, 10'h0, up_oe}, 32'h0); // address floated
		check({29'h0, cw_oe[1], cw_out[1], ready}, 32'h4); // clock low
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		wbc(ext_bus_pkg::STATUS_OFS, 32'h1);
		wbc(ext_bus_pkg::CTL_CFG_OFS, 32'h0);
		$display("test standby done");
		give_verdict();
	end
endmodule : tb_ext_mux_bus_pins
